//--- core/pio_ctrl.sv
// apb register block of the 32-line parallel io controller
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "pio_regs.svh"
// =====================================================
module pio_ctrl #(
  parameter logic [31:0] LINES_PRESENT = 32'hFFFF_FFFF,
  parameter logic [31:0] LINES_MUXED = 32'hFFFF_FFFF,
  parameter logic [31:0] OWN_RESET = 32'hFFFF_FFFF
) (
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PIN_LEVEL_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT,
  output pio_pkg::pio_pad_t PAD_OUT
);
  import pio_pkg::*;
  pio_state_t r;
  pio_state_t next_r;
  pio_pad_t pad;
  logic acc;
  logic wr;
  logic rd;
  logic [31:0] wd;
  logic [31:0] own_fix;

  // =====================================================
  // helpers
  function automatic logic [31:0] setclr(input logic [31:0] cur,
    input logic s, input logic c, input logic [31:0] d);
    setclr = s ? (cur | d) : (c ? (cur & ~d) : cur);
  endfunction

  assign acc = PSEL_IN && PENABLE_IN && !r.pready;
  assign wr = acc && PWRITE_IN;
  assign rd = acc && !PWRITE_IN;
  assign wd = PWDATA_IN & LINES_PRESENT;
  assign own_fix = (~LINES_MUXED) & LINES_PRESENT;

  // =====================================================
  // next state
  always_comb
  begin
    logic [31:0] chg;
    chg = `PIO_ZERO;
    next_r = r;
    next_r.s1 = PIN_LEVEL_IN;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // filter takes a level once two samples agree
    next_r.filt = (~r.gf & r.s2) | (r.gf & ~(r.s2 ^ r.s3) & r.s2)
      | (r.gf & (r.s2 ^ r.s3) & r.filt);
    next_r.prev = r.filt;
    next_r.primed = 1'b1;
    chg = r.primed ? ((r.filt ^ r.prev) & LINES_PRESENT) : `PIO_ZERO;
    next_r.pready = acc;
    next_r.own = setclr(r.own, wr && PADDR_IN == `PIO_OWN_EN,
      wr && PADDR_IN == `PIO_OWN_DIS, wd) | own_fix;
    next_r.oe = setclr(r.oe, wr && PADDR_IN == `PIO_OE_SET,
      wr && PADDR_IN == `PIO_OE_CLR, wd);
    next_r.gf = setclr(r.gf, wr && PADDR_IN == `PIO_GF_SET,
      wr && PADDR_IN == `PIO_GF_CLR, wd);
    next_r.dl = setclr(r.dl, wr && PADDR_IN == `PIO_DL_SET,
      wr && PADDR_IN == `PIO_DL_CLR, wd);
    if (wr && PADDR_IN == `PIO_DL_STAT)
      next_r.dl = (r.dl & ~r.dw) | (wd & r.dw);
    next_r.mask = setclr(r.mask, wr && PADDR_IN == `PIO_IRQ_EN,
      wr && PADDR_IN == `PIO_IRQ_DIS, wd);
    next_r.od = setclr(r.od, wr && PADDR_IN == `PIO_OD_SET,
      wr && PADDR_IN == `PIO_OD_CLR, wd);
    next_r.pu = setclr(r.pu, wr && PADDR_IN == `PIO_PU_SET,
      wr && PADDR_IN == `PIO_PU_CLR, wd);
    next_r.pc = setclr(r.pc, wr && PADDR_IN == `PIO_PS_SEL,
      wr && PADDR_IN == `PIO_PF_SEL, wd);
    next_r.dw = setclr(r.dw, wr && PADDR_IN == `PIO_DW_EN,
      wr && PADDR_IN == `PIO_DW_DIS, wd);
    // new change wins over read clear
    if (rd && PADDR_IN == `PIO_IRQ_PEND)
      next_r.pend = chg;
    else
      next_r.pend = r.pend | chg;
    next_r.irq = |(next_r.pend & next_r.mask);
    next_r.prdata = r.prdata;
    if (rd)
    begin
      unique case (PADDR_IN)
        `PIO_OWN_STAT: next_r.prdata = r.own;
        `PIO_OE_STAT: next_r.prdata = r.oe;
        `PIO_GF_STAT: next_r.prdata = r.gf;
        `PIO_DL_STAT: next_r.prdata = r.dl;
        `PIO_PIN_RB: next_r.prdata = r.filt;
        `PIO_IRQ_MASK: next_r.prdata = r.mask;
        `PIO_IRQ_PEND: next_r.prdata = r.pend;
        `PIO_OD_STAT: next_r.prdata = r.od;
        `PIO_PU_STAT: next_r.prdata = r.pu;
        `PIO_PC_STAT: next_r.prdata = r.pc;
        `PIO_DW_STAT: next_r.prdata = r.dw;
        default: next_r.prdata = `PIO_ZERO;
      endcase
      next_r.prdata = next_r.prdata & LINES_PRESENT;
    end
  end

  // =====================================================
  // registers
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      r <= '0;
      r.own <= (OWN_RESET | own_fix) & LINES_PRESENT;
    end
    else
      r <= next_r;
  end

  always_comb
  begin
    pad.own = r.own;
    pad.oe = r.oe;
    pad.dl = r.dl;
    pad.od = r.od;
    pad.pu = r.pu;
    pad.pc = r.pc;
  end

  assign PRDATA_OUT = r.prdata;
  assign PREADY_OUT = r.pready;
  assign PSLVERR_OUT = 1'b0;
  assign IRQ_OUT = r.irq;
  assign PAD_OUT = pad;

  // =====================================================
  // assertions
  property p_own_en;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_OWN_EN |=> ((r.own & $past(wd)) == $past(wd));
  endproperty
  a_own_en: assert property (p_own_en) else $error("own set");
  property p_own_dis;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_OWN_DIS
      |=> ((r.own & $past(wd) & ~own_fix) == `PIO_ZERO);
  endproperty
  a_own_dis: assert property (p_own_dis) else $error("own clr");
  property p_fix;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    ((r.own & own_fix) == own_fix);
  endproperty
  a_fix: assert property (p_fix) else $error("fixed own");
  property p_oe;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_OE_SET |=> ((r.oe & $past(wd)) == $past(wd));
  endproperty
  a_oe: assert property (p_oe) else $error("oe set");
  property p_dw;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_DL_STAT
      |=> ((r.dl & ~$past(r.dw)) == ($past(r.dl) & ~$past(r.dw)));
  endproperty
  a_dw: assert property (p_dw) else $error("masked write");
  property p_pc;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_PF_SEL |=> ((r.pc & $past(wd)) == `PIO_ZERO);
  endproperty
  a_pc: assert property (p_pc) else $error("sel a");
  property p_clr;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    rd && PADDR_IN == `PIO_IRQ_PEND |=> (PRDATA_OUT == $past(r.pend));
  endproperty
  a_clr: assert property (p_clr) else $error("pend read");
  property p_irq;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    IRQ_OUT == |(r.pend & r.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_rsv;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    rd && PADDR_IN == `PIO_OWN_EN |=> PRDATA_OUT == `PIO_ZERO;
  endproperty
  a_rsv: assert property (p_rsv) else $error("wo read");
  property p_rdy;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
  property p_oe_clr;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_OE_CLR |=> ((r.oe & $past(wd)) == `PIO_ZERO);
  endproperty
  a_oe_clr: assert property (p_oe_clr) else $error("oe clr");
  property p_gf_set;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_GF_SET |=> ((r.gf & $past(wd)) == $past(wd));
  endproperty
  a_gf_set: assert property (p_gf_set) else $error("gf set");
  property p_gf_clr;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_GF_CLR |=> ((r.gf & $past(wd)) == `PIO_ZERO);
  endproperty
  a_gf_clr: assert property (p_gf_clr) else $error("gf clr");
  property p_dl_set;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_DL_SET |=> ((r.dl & $past(wd)) == $past(wd));
  endproperty
  a_dl_set: assert property (p_dl_set) else $error("dl set");
  property p_dl_clr;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_DL_CLR |=> ((r.dl & $past(wd)) == `PIO_ZERO);
  endproperty
  a_dl_clr: assert property (p_dl_clr) else $error("dl clr");
  property p_dw_wr;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_DL_STAT
      |=> ((r.dl & $past(r.dw)) == ($past(wd) & $past(r.dw)));
  endproperty
  a_dw_wr: assert property (p_dw_wr) else $error("direct write");
  property p_mask_set;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_IRQ_EN |=> ((r.mask & $past(wd)) == $past(wd));
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask");
  property p_mask_clr;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_IRQ_DIS |=> ((r.mask & $past(wd)) == `PIO_ZERO);
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("unmask");
  property p_od_set;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_OD_SET |=> ((r.od & $past(wd)) == $past(wd));
  endproperty
  a_od_set: assert property (p_od_set) else $error("od set");
  property p_od_clr;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_OD_CLR |=> ((r.od & $past(wd)) == `PIO_ZERO);
  endproperty
  a_od_clr: assert property (p_od_clr) else $error("od clr");
  property p_pu_set;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_PU_SET |=> ((r.pu & $past(wd)) == $past(wd));
  endproperty
  a_pu_set: assert property (p_pu_set) else $error("pu set");
  property p_pu_clr;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_PU_CLR |=> ((r.pu & $past(wd)) == `PIO_ZERO);
  endproperty
  a_pu_clr: assert property (p_pu_clr) else $error("pu clr");
  property p_pc_b;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_PS_SEL |=> ((r.pc & $past(wd)) == $past(wd));
  endproperty
  a_pc_b: assert property (p_pc_b) else $error("sel b");
  property p_dw_en;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_DW_EN |=> ((r.dw & $past(wd)) == $past(wd));
  endproperty
  a_dw_en: assert property (p_dw_en) else $error("dw en");
  property p_dw_dis;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr && PADDR_IN == `PIO_DW_DIS |=> ((r.dw & $past(wd)) == `PIO_ZERO);
  endproperty
  a_dw_dis: assert property (p_dw_dis) else $error("dw dis");
  property p_abs;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    ((r.oe | r.gf | r.dl | r.mask | r.od | r.pu | r.pc | r.dw | r.own
      | r.pend) & ~LINES_PRESENT) == `PIO_ZERO;
  endproperty
  a_abs: assert property (p_abs) else $error("absent bits");
  property p_prd_abs;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (PRDATA_OUT & ~LINES_PRESENT) == `PIO_ZERO;
  endproperty
  a_prd_abs: assert property (p_prd_abs) else $error("read bits");
  property p_pend_hold;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    !(rd && PADDR_IN == `PIO_IRQ_PEND)
      |=> ((r.pend & $past(r.pend)) == $past(r.pend));
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pend");
  property p_wo_rd;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    rd && PADDR_IN == `PIO_OE_SET |=> PRDATA_OUT == `PIO_ZERO;
  endproperty
  a_wo_rd: assert property (p_wo_rd) else $error("wo read");
  property p_rsv_rd;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    rd && PADDR_IN == 8'h0C |=> PRDATA_OUT == `PIO_ZERO;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("rsv read");
  property p_rdy_pulse;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    PREADY_OUT |=> !PREADY_OUT;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pulse");
  property p_own_rd;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    rd && PADDR_IN == `PIO_OWN_STAT |=> PRDATA_OUT == $past(r.own);
  endproperty
  a_own_rd: assert property (p_own_rd) else $error("own read");
  property p_pin_rd;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    rd && PADDR_IN == `PIO_PIN_RB
      |=> PRDATA_OUT == ($past(r.filt) & LINES_PRESENT);
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read");
  c_filt: cover property (@(posedge CORE_CLK_IN)
    (r.gf & (r.s2 ^ r.s3)) != `PIO_ZERO);
  c_own: cover property (@(posedge CORE_CLK_IN)
    wr && PADDR_IN == `PIO_OWN_DIS);
  c_irq: cover property (@(posedge CORE_CLK_IN) IRQ_OUT);
  c_dw: cover property (@(posedge CORE_CLK_IN)
    wr && PADDR_IN == `PIO_DL_STAT && r.dw != `PIO_ZERO);
  c_rd: cover property (@(posedge CORE_CLK_IN)
    rd && PADDR_IN == `PIO_IRQ_PEND && r.pend != `PIO_ZERO);
endmodule // pio_ctrl

//--- include/pio_regs.svh
// register offsets and the zero constant of the parallel io controller
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH
`define PIO_OWN_EN 8'h00
`define PIO_OWN_DIS 8'h04
`define PIO_OWN_STAT 8'h08
`define PIO_OE_SET 8'h10
`define PIO_OE_CLR 8'h14
`define PIO_OE_STAT 8'h18
`define PIO_GF_SET 8'h20
`define PIO_GF_CLR 8'h24
`define PIO_GF_STAT 8'h28
`define PIO_DL_SET 8'h30
`define PIO_DL_CLR 8'h34
`define PIO_DL_STAT 8'h38
`define PIO_PIN_RB 8'h3C
`define PIO_IRQ_EN 8'h40
`define PIO_IRQ_DIS 8'h44
`define PIO_IRQ_MASK 8'h48
`define PIO_IRQ_PEND 8'h4C
`define PIO_OD_SET 8'h50
`define PIO_OD_CLR 8'h54
`define PIO_OD_STAT 8'h58
`define PIO_PU_CLR 8'h60
`define PIO_PU_SET 8'h64
`define PIO_PU_STAT 8'h68
`define PIO_PF_SEL 8'h70
`define PIO_PS_SEL 8'h74
`define PIO_PC_STAT 8'h78
`define PIO_DW_EN 8'hA0
`define PIO_DW_DIS 8'hA4
`define PIO_DW_STAT 8'hA8
`define PIO_ZERO 32'h0000_0000
`endif

//--- include/pio_pkg.sv
// types of the parallel io controller
package pio_pkg;
  typedef struct packed {
    logic [31:0] own;
    logic [31:0] oe;
    logic [31:0] gf;
    logic [31:0] dl;
    logic [31:0] mask;
    logic [31:0] pend;
    logic [31:0] od;
    logic [31:0] pu;
    logic [31:0] pc;
    logic [31:0] dw;
    logic [31:0] s1;
    logic [31:0] s2;
    logic [31:0] s3;
    logic [31:0] filt;
    logic [31:0] prev;
    logic primed;
    logic [31:0] prdata;
    logic pready;
    logic irq;
  } pio_state_t;
  typedef struct packed {
    logic [31:0] own;
    logic [31:0] oe;
    logic [31:0] dl;
    logic [31:0] od;
    logic [31:0] pu;
    logic [31:0] pc;
  } pio_pad_t;
endpackage

//--- sim/pio_pins.sv
// pad model returning line levels to the controller
`timescale 1ns/1ns
module pio_pins (
  input pio_pkg::pio_pad_t pad_in,
  input wire logic [31:0] ext_in,
  output logic [31:0] lvl_out
);
  import pio_pkg::*;
  logic [31:0] drv;
  // owned output lines drive, open drain lets a high float to ext
  assign drv = pad_in.own & pad_in.oe & ~(pad_in.od & pad_in.dl);
  assign lvl_out = (drv & pad_in.dl) | (~drv & ext_in);
endmodule // pio_pins

//--- sim/parallel_io_register_interface_bench.sv
// self-checking bench of the parallel io register block
`timescale 1ns/1ns
`include "pio_regs.svh"
module parallel_io_register_interface_bench;
  import pio_pkg::*;
  localparam logic [31:0] PRES = 32'h7FFF_FFFF;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] ext = 32'h0000_0000;
  logic [31:0] lvl, prd, rv;
  logic rdy, irq;
  pio_pad_t pad;
  int n_errors = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  pio_ctrl #(.LINES_PRESENT(PRES), .LINES_MUXED(32'hFFFF_0000),
    .OWN_RESET(32'h00F0_0000)) dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa),
    .PWDATA_IN(pwd), .PIN_LEVEL_IN(lvl), .PRDATA_OUT(prd),
    .PREADY_OUT(rdy), .PSLVERR_OUT(), .IRQ_OUT(irq), .PAD_OUT(pad));
  pio_pins pins (.pad_in(pad), .ext_in(ext), .lvl_out(lvl));
  // ==========
  // tasks
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 9);
    rv = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    if (k == 9)
    begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, `PIO_ZERO);
    check($sformatf("reg %h", a), rv, exp);
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    logic [7:0] z[11] = '{`PIO_OE_STAT, `PIO_GF_STAT, `PIO_IRQ_MASK,
      `PIO_IRQ_PEND, `PIO_OD_STAT, `PIO_PU_STAT, `PIO_PC_STAT,
      `PIO_DW_STAT, `PIO_OWN_EN, 8'h0C, 8'hAC};
    for (int i = 0; i < 11; i++)
      rd(z[i], `PIO_ZERO);
    rd(`PIO_OWN_STAT, 32'h00F0_FFFF);
    $display("test reset done");
  endtask
  task automatic t_pairs();
    logic [7:0] s[8] = '{`PIO_OE_SET, `PIO_GF_SET, `PIO_DL_SET,
      `PIO_IRQ_EN, `PIO_OD_SET, `PIO_PU_SET, `PIO_PS_SEL, `PIO_DW_EN};
    logic [7:0] c[8] = '{`PIO_OE_CLR, `PIO_GF_CLR, `PIO_DL_CLR,
      `PIO_IRQ_DIS, `PIO_OD_CLR, `PIO_PU_CLR, `PIO_PF_SEL, `PIO_DW_DIS};
    logic [7:0] t[8] = '{`PIO_OE_STAT, `PIO_GF_STAT, `PIO_DL_STAT,
      `PIO_IRQ_MASK, `PIO_OD_STAT, `PIO_PU_STAT, `PIO_PC_STAT,
      `PIO_DW_STAT};
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, s[i], 32'hFFFF_FFFF);
      rd(t[i], PRES);
      apb(1'b1, c[i], 32'h0000_FFFF);
      rd(t[i], 32'h7FFF_0000);
    end
    apb(1'b1, `PIO_OWN_DIS, 32'hFFFF_FFFF);
    rd(`PIO_OWN_STAT, 32'h0000_FFFF);
    apb(1'b1, `PIO_OWN_EN, 32'h8F00_0000);
    rd(`PIO_OWN_STAT, 32'h0F00_FFFF);
    apb(1'b1, `PIO_DW_DIS, 32'hFFFF_FFFF);
    apb(1'b1, `PIO_DW_EN, 32'h0000_0FF0);
    apb(1'b1, `PIO_DL_STAT, 32'h0000_0A5F);
    rd(`PIO_DL_STAT, 32'h7FFF_0A50);
    check("pad dl", pad.dl, 32'h7FFF_0A50);
    $display("test pairs done");
  endtask
  task automatic t_pins();
    rd(`PIO_IRQ_PEND, 32'h00F0_0000);
    apb(1'b1, `PIO_OD_CLR, 32'h0100_0000);
    ext <= 32'h8000_1234;
    repeat (8) @(posedge clk);
    rd(`PIO_PIN_RB, 32'h0100_1234);
    check("irq on", {31'h0, irq}, 32'h0000_0001);
    rd(`PIO_IRQ_PEND, 32'h0100_1234);
    @(posedge clk);
    check("irq off", {31'h0, irq}, `PIO_ZERO);
    rd(`PIO_IRQ_PEND, `PIO_ZERO);
    ext <= 32'h0000_123C;
    repeat (8) @(posedge clk);
    check("irq masked", {31'h0, irq}, `PIO_ZERO);
    rd(`PIO_IRQ_PEND, 32'h0000_0008);
    $display("test pins done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_pairs();
    t_pins();
    complete_run();
  end
endmodule // parallel_io_register_interface_bench
